// *** verilog/tsm_pkg.sv ***
// Constants and carrier types for the two-pin test signal selector.
// Assumes the select codes arrive from a configuration register outside this block.
package tsm_pkg;

  localparam int SEL_WIDTH = 5;

  // ****************************************************************
  // Select codes
  // ****************************************************************
  localparam logic [4:0] SEL_NORMAL = 5'h00;
  localparam logic [4:0] SEL_CONV_LSB = 5'h01;
  localparam logic [4:0] SEL_RESYNC = 5'h02;
  localparam logic [4:0] SEL_LOCK = 5'h03;
  localparam logic [4:0] SEL_MOD_A = 5'h04;
  localparam logic [4:0] SEL_MOD_B = 5'h05;
  localparam logic [4:0] SEL_PD_FIRST = 5'h06;
  localparam logic [4:0] SEL_PD_LAST = 5'h0b;
  localparam logic [4:0] SEL_C12 = 5'h0c;
  localparam logic [4:0] SEL_C13 = 5'h0d;
  localparam logic [4:0] SEL_C14 = 5'h0e;
  localparam logic [4:0] SEL_FE_GAIN = 5'h0f;
  localparam logic [4:0] SEL_AMP_GAIN = 5'h10;
  localparam logic [4:0] SEL_C17 = 5'h11;
  localparam logic [4:0] SEL_HALF_CLK = 5'h17;
  localparam logic [4:0] SEL_C24 = 5'h18;
  localparam logic [4:0] SEL_SYN_FIRST = 5'h19;
  localparam logic [4:0] SEL_SYN_LAST = 5'h1c;
  localparam logic [4:0] SEL_CONV_CLK = 5'h1d;
  localparam logic [4:0] SEL_ZERO = 5'h1e;
  localparam logic [4:0] SEL_ONE = 5'h1f;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic RST_PIN = 1'b0;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  // Power-down controls in select order, index 0 is select 6
  typedef struct packed {
    logic power_amp_powerdown;
    logic rx_frontend_powerdown;
    logic rx_filter_powerdown;
    logic amp_powerdown;
    logic converter_powerdown;
    logic synth_powerdown;
  } tsm_pd_t;

  // Synthesizer timing signals, index 0 is select 25
  typedef struct packed {
    logic synth_lock_window_sync;
    logic synth_lock_window;
    logic synth_div_tick;
    logic synth_ref_tick;
  } tsm_synth_t;

  typedef struct packed {
    logic frame_delimiter;
    logic clear_channel;
    logic conv_q_lsb;
    logic conv_i_lsb;
    logic late_resync_pulse;
    logic early_resync_pulse;
    logic synth_lock;
    logic chip_rate_clock;
    logic bit_rate_clock;
    logic chip_stream;
    logic bit_stream;
    logic gain_update_pulse;
    logic [4:0] amp_peak_flags;
    logic [1:0] frontend_gain_setting;
    logic [1:0] amp_gain_setting;
    logic amp_peak_reset_n;
    logic filter_cal_clock;
    logic half_xtal_clock;
    logic xtal_stable_flag;
    logic synth_freq_compare;
    logic converter_clock_a;
    logic converter_clock_b;
    tsm_pd_t pd;
    tsm_synth_t synth;
  } tsm_sources_t;

endpackage

// *** verilog/tsm_test_mux.sv ***
// Two 32-way selectors that drive the frame-delimiter and channel-clear pins.
// Assumes all sources are synchronous to i_clk and selects come from io_config_one.
//
// Notes on behaviour
// [R1] Each pin has its own test select field
// [R2] Frame pin select 1: Q converter LSB
// [R3] Clear pin select 1: I converter LSB
// [R4] Frame pin select 2: late resync pulse
// [R5] Clear pin select 2: early resync pulse
// [R6] Select 3 on either pin: synth lock
// [R7] Frame pin 4/5: chip and bit clocks
// [R8] Clear pin 4/5: chip and bit data
// [R9] Selects 6-11: power-down controls in order
// [R10] Frame pin select 12: gain update pulse
// [R11] Frame pin 13/14: peak flags 1, 3
// [R12] Clear pin 12-14: peak flags 0, 2, 4
// [R13] 15/16 gain bits: frame bit1, clear bit0
// [R14] Frame pin select 17: peak detector reset
// [R15] Clear pin select 17: filter calibration clock
// [R16] Frame pin select 23: half crystal clock
// [R17] Frame pin select 24: crystal stable flag
// [R18] Clear pin select 24: frequency comparator
// [R19] Selects 25-28: synthesizer timing signals
// [R20] 29 converter clock, 30 low, 31 high
// [R21] Software avoids reserved select codes
// [R22] Select 0 restores normal pin function
`timescale 1ns/100ps

module tsm_test_mux
  import tsm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [tsm_pkg::SEL_WIDTH-1:0] i_frame_pin_select,
  input wire logic [tsm_pkg::SEL_WIDTH-1:0] i_clear_pin_select,
  input wire tsm_pkg::tsm_sources_t i_src,
  output logic o_frame_pin,
  output logic o_clear_pin
);
  import tsm_pkg::*;

  // ****************************************************************
  // Frame-delimiter pin
  // ****************************************************************
  // Bit 0 of the pin vectors is the frame-delimiter pin, bit 1 the
  // clear-channel pin.
  localparam int PIN_COUNT = 2;

  logic next_frame_pin;
  logic next_clear_pin;
  logic [PIN_COUNT-1:0] next_pin;
  logic [PIN_COUNT-1:0] pin;

  // Each pin reads only its own select field [R1]
  always_comb begin
    unique case (i_frame_pin_select)
      // Normal function and receive samples
      SEL_NORMAL: begin
        next_frame_pin = i_src.frame_delimiter; // [R22]
      end

      SEL_CONV_LSB: begin
        next_frame_pin = i_src.conv_q_lsb; // [R2]
      end

      SEL_RESYNC: begin
        next_frame_pin = i_src.late_resync_pulse; // [R4]
      end

      SEL_LOCK: begin
        next_frame_pin = i_src.synth_lock; // [R6]
      end

      // Modulator timing; it only toggles while transmitting, so outside
      // a transmission the pin shows whatever idle level the source holds
      SEL_MOD_A: begin
        next_frame_pin = i_src.chip_rate_clock; // [R7]
      end

      SEL_MOD_B: begin
        next_frame_pin = i_src.bit_rate_clock; // [R7]
      end

      // Power-down controls, active high
      SEL_PD_FIRST: begin
        next_frame_pin = i_src.pd.synth_powerdown; // [R9]
      end

      SEL_PD_FIRST + 5'h01: begin
        next_frame_pin = i_src.pd.converter_powerdown; // [R9]
      end

      SEL_PD_FIRST + 5'h02: begin
        next_frame_pin = i_src.pd.amp_powerdown; // [R9]
      end

      SEL_PD_FIRST + 5'h03: begin
        next_frame_pin = i_src.pd.rx_filter_powerdown; // [R9]
      end

      SEL_PD_FIRST + 5'h04: begin
        next_frame_pin = i_src.pd.rx_frontend_powerdown; // [R9]
      end

      SEL_PD_LAST: begin
        next_frame_pin = i_src.pd.power_amp_powerdown; // [R9]
      end

      // Gain control; this pin carries the odd peak stages and the
      // upper bit of each gain field
      SEL_C12: begin
        next_frame_pin = i_src.gain_update_pulse; // [R10]
      end

      SEL_C13: begin
        next_frame_pin = i_src.amp_peak_flags[1]; // [R11]
      end

      SEL_C14: begin
        next_frame_pin = i_src.amp_peak_flags[3]; // [R11]
      end

      SEL_FE_GAIN: begin
        next_frame_pin = i_src.frontend_gain_setting[1]; // [R13]
      end

      SEL_AMP_GAIN: begin
        next_frame_pin = i_src.amp_gain_setting[1]; // [R13]
      end

      SEL_C17: begin
        next_frame_pin = i_src.amp_peak_reset_n; // [R14]
      end

      // Clock and oscillator status; a routed clock is resampled by
      // i_clk and survives only below half of its rate
      SEL_HALF_CLK: begin
        next_frame_pin = i_src.half_xtal_clock; // [R16]
      end

      SEL_C24: begin
        next_frame_pin = i_src.xtal_stable_flag; // [R17]
      end

      // Synthesizer timing
      SEL_SYN_FIRST: begin
        next_frame_pin = i_src.synth.synth_ref_tick; // [R19]
      end

      SEL_SYN_FIRST + 5'h01: begin
        next_frame_pin = i_src.synth.synth_div_tick; // [R19]
      end

      SEL_SYN_FIRST + 5'h02: begin
        next_frame_pin = i_src.synth.synth_lock_window; // [R19]
      end

      SEL_SYN_LAST: begin
        next_frame_pin = i_src.synth.synth_lock_window_sync; // [R19]
      end

      // Converter clock and fixed levels
      SEL_CONV_CLK: begin
        next_frame_pin = i_src.converter_clock_a; // [R20]
      end

      SEL_ZERO: begin
        next_frame_pin = 1'b0; // [R20]
      end

      SEL_ONE: begin
        next_frame_pin = 1'b1; // [R20]
      end

      // Reserved codes have no defined output; a quiet low pin is the
      // safest thing to show if software programs one anyway
      SEL_C17 + 5'h01,
      SEL_C17 + 5'h02,
      SEL_C17 + 5'h03,
      SEL_C17 + 5'h04,
      SEL_C17 + 5'h05: begin
        next_frame_pin = 1'b0; // [R21]
      end
    endcase
  end

  // ****************************************************************
  // Clear-channel pin
  // ****************************************************************
  // Each pin reads only its own select field [R1]
  always_comb begin
    unique case (i_clear_pin_select)
      // Normal function and receive samples
      SEL_NORMAL: begin
        next_clear_pin = i_src.clear_channel; // [R22]
      end

      SEL_CONV_LSB: begin
        next_clear_pin = i_src.conv_i_lsb; // [R3]
      end

      SEL_RESYNC: begin
        next_clear_pin = i_src.early_resync_pulse; // [R5]
      end

      SEL_LOCK: begin
        next_clear_pin = i_src.synth_lock; // [R6]
      end

      // Modulator data; it only moves while transmitting, so outside
      // a transmission the pin shows whatever idle level the source holds
      SEL_MOD_A: begin
        next_clear_pin = i_src.chip_stream; // [R8]
      end

      SEL_MOD_B: begin
        next_clear_pin = i_src.bit_stream; // [R8]
      end

      // Power-down controls, active high
      SEL_PD_FIRST: begin
        next_clear_pin = i_src.pd.synth_powerdown; // [R9]
      end

      SEL_PD_FIRST + 5'h01: begin
        next_clear_pin = i_src.pd.converter_powerdown; // [R9]
      end

      SEL_PD_FIRST + 5'h02: begin
        next_clear_pin = i_src.pd.amp_powerdown; // [R9]
      end

      SEL_PD_FIRST + 5'h03: begin
        next_clear_pin = i_src.pd.rx_filter_powerdown; // [R9]
      end

      SEL_PD_FIRST + 5'h04: begin
        next_clear_pin = i_src.pd.rx_frontend_powerdown; // [R9]
      end

      SEL_PD_LAST: begin
        next_clear_pin = i_src.pd.power_amp_powerdown; // [R9]
      end

      // Gain control; this pin carries the even peak stages and the
      // lower bit of each gain field
      SEL_C12: begin
        next_clear_pin = i_src.amp_peak_flags[0]; // [R12]
      end

      SEL_C13: begin
        next_clear_pin = i_src.amp_peak_flags[2]; // [R12]
      end

      SEL_C14: begin
        next_clear_pin = i_src.amp_peak_flags[4]; // [R12]
      end

      SEL_FE_GAIN: begin
        next_clear_pin = i_src.frontend_gain_setting[0]; // [R13]
      end

      SEL_AMP_GAIN: begin
        next_clear_pin = i_src.amp_gain_setting[0]; // [R13]
      end

      SEL_C17: begin
        next_clear_pin = i_src.filter_cal_clock; // [R15]
      end

      // Synthesizer comparator and timing; the ticks are resampled by
      // i_clk and survive only below half of its rate
      SEL_C24: begin
        next_clear_pin = i_src.synth_freq_compare; // [R18]
      end

      SEL_SYN_FIRST: begin
        next_clear_pin = i_src.synth.synth_ref_tick; // [R19]
      end

      SEL_SYN_FIRST + 5'h01: begin
        next_clear_pin = i_src.synth.synth_div_tick; // [R19]
      end

      SEL_SYN_FIRST + 5'h02: begin
        next_clear_pin = i_src.synth.synth_lock_window; // [R19]
      end

      SEL_SYN_LAST: begin
        next_clear_pin = i_src.synth.synth_lock_window_sync; // [R19]
      end

      // Converter clock and fixed levels
      SEL_CONV_CLK: begin
        next_clear_pin = i_src.converter_clock_b; // [R20]
      end

      SEL_ZERO: begin
        next_clear_pin = 1'b0; // [R20]
      end

      SEL_ONE: begin
        next_clear_pin = 1'b1; // [R20]
      end

      // Reserved codes have no defined output; a quiet low pin is the
      // safest thing to show if software programs one anyway
      SEL_C17 + 5'h01,
      SEL_C17 + 5'h02,
      SEL_C17 + 5'h03,
      SEL_C17 + 5'h04,
      SEL_C17 + 5'h05,
      SEL_HALF_CLK: begin
        next_clear_pin = 1'b0; // [R21]
      end
    endcase
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************
  // One register stage keeps pin outputs glitch free; one-cycle pulses
  // stay one cycle wide, only delayed by one clock. The price is that
  // every test signal reaches its pin one clock late, which matters
  // only when a pin is compared against a signal that bypasses this register.
  assign next_pin = {next_clear_pin, next_frame_pin};

  // One identical register per pin
  generate
    for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
      always_ff @(posedge i_clk) begin
        if (i_reset) begin
          pin[p] <= RST_PIN;
        end else begin
          pin[p] <= next_pin[p];
        end
      end
    end
  endgenerate

  assign o_frame_pin = pin[0];
  assign o_clear_pin = pin[1];

endmodule

// *** testbench/tsm_test_mux_sva.sv ***
// Port checker for the two-pin test signal selector.
// Assumes one clock domain; bound into every tsm_test_mux.
`timescale 1ns/100ps
module tsm_test_mux_chk
  import tsm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [tsm_pkg::SEL_WIDTH-1:0] i_frame_pin_select,
  input wire logic [tsm_pkg::SEL_WIDTH-1:0] i_clear_pin_select,
  input wire tsm_pkg::tsm_sources_t i_src,
  input wire logic o_frame_pin,
  input wire logic o_clear_pin
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  reset_clear_a: assert property (disable iff (1'b0) i_reset
    |=> !o_frame_pin && !o_clear_pin) else $error("pin high after reset");
  frame_q_lsb_a: assert property (i_frame_pin_select == 5'h01
    |=> o_frame_pin == $past(i_src.conv_q_lsb)) else $error("frame q lsb");
  clear_i_lsb_a: assert property (i_clear_pin_select == 5'h01
    |=> o_clear_pin == $past(i_src.conv_i_lsb)) else $error("clear i lsb");
  late_pulse_a: assert property ((i_frame_pin_select == 5'h02 && i_src.late_resync_pulse)
    ##1 ($stable(i_frame_pin_select) && !i_src.late_resync_pulse)
    |-> o_frame_pin ##1 !o_frame_pin) else $error("late pulse width");
  early_pulse_a: assert property ((i_clear_pin_select == 5'h02 && i_src.early_resync_pulse)
    ##1 ($stable(i_clear_pin_select) && !i_src.early_resync_pulse)
    |-> o_clear_pin ##1 !o_clear_pin) else $error("early pulse width");
  lock_both_a: assert property ((i_frame_pin_select == 5'h03)
    && (i_clear_pin_select == 5'h03) |=> o_frame_pin == $past(i_src.synth_lock)
    && o_clear_pin == o_frame_pin) else $error("lock status");
  powerdown_a: assert property (i_frame_pin_select inside {[5'h06:5'h0b]}
    |=> o_frame_pin == $past(i_src.pd[i_frame_pin_select - 5'h06])) else $error("powerdown");
  normal_mode_a: assert property (i_frame_pin_select == 5'h00 && i_clear_pin_select == 5'h00
    |=> {o_frame_pin, o_clear_pin} == $past({i_src.frame_delimiter, i_src.clear_channel}))
    else $error("normal function");
endmodule
bind tsm_test_mux tsm_test_mux_chk chk (.i_clk(i_clk), .i_reset(i_reset),
  .i_frame_pin_select(i_frame_pin_select), .i_clear_pin_select(i_clear_pin_select),
  .i_src(i_src), .o_frame_pin(o_frame_pin), .o_clear_pin(o_clear_pin));

// *** testbench/tsm_pin_probe.sv ***
// Bench pin probe: counts clock cycles each test pin is seen high.
// Assumes pins settle before the rising edge of i_clk.
`timescale 1ns/100ps
module tsm_pin_probe (
  input wire logic i_clk,
  input wire logic i_frame_pin,
  input wire logic i_clear_pin,
  output logic [7:0] o_frame_highs = 8'h00,
  output logic [7:0] o_clear_highs = 8'h00
);
  // Counting highs, not edges, exposes a pulse stretched past one cycle
  always @(posedge i_clk) begin
    o_frame_highs <= o_frame_highs + {7'h00, i_frame_pin === 1'b1};
    o_clear_highs <= o_clear_highs + {7'h00, i_clear_pin === 1'b1};
  end
endmodule

// *** testbench/tb_test_signal_output_mux.sv ***
// Self-checking bench for the two-pin test signal selector.
// Assumes the probe and checker files are compiled first.
`timescale 1ns/100ps
module tb_test_signal_output_mux;
  import tsm_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [4:0] fs = 5'h00;
  logic [4:0] cs = 5'h00;
  tsm_sources_t src = '0;
  logic o_f;
  logic o_c;
  logic [7:0] f_hi;
  logic [7:0] c_hi;
  int fail_count = 0;
  int checks = 0;
  always #10 i_clk = ~i_clk;
  tsm_test_mux uut (.i_clk(i_clk), .i_reset(i_reset), .i_frame_pin_select(fs),
    .i_clear_pin_select(cs), .i_src(src), .o_frame_pin(o_f), .o_clear_pin(o_c));
  tsm_pin_probe probe (.i_clk(i_clk), .i_frame_pin(o_f), .i_clear_pin(o_c),
    .o_frame_highs(f_hi), .o_clear_highs(c_hi));
  // Bit k of v is the source for select code k; reserved codes read low
  function automatic logic pin_exp(input bit f, input logic [4:0] k, input tsm_sources_t s);
    logic [31:0] v;
    if (f) begin
      v = {2'h2, s.converter_clock_a, s.synth, s.xtal_stable_flag, s.half_xtal_clock, 5'h00,
        s.amp_peak_reset_n, s.amp_gain_setting[1], s.frontend_gain_setting[1],
        s.amp_peak_flags[3], s.amp_peak_flags[1], s.gain_update_pulse, s.pd, s.bit_rate_clock,
        s.chip_rate_clock, s.synth_lock, s.late_resync_pulse, s.conv_q_lsb, s.frame_delimiter};
    end else begin
      v = {2'h2, s.converter_clock_b, s.synth, s.synth_freq_compare, 6'h00, s.filter_cal_clock,
        s.amp_gain_setting[0], s.frontend_gain_setting[0], s.amp_peak_flags[4],
        s.amp_peak_flags[2], s.amp_peak_flags[0], s.pd, s.bit_stream, s.chip_stream,
        s.synth_lock, s.early_resync_pulse, s.conv_i_lsb, s.clear_channel};
    end
    return v[k];
  endfunction
  task automatic cmp(input logic got, input logic want);
    checks++;
    if (got !== want) begin
      fail_count++;
      $display("Error %0t: pin %b, expected %b", $time, got, want);
    end
  endtask
  task automatic cmp_n(input logic [7:0] got, input logic [7:0] want);
    checks++;
    if (got !== want) begin
      fail_count++;
      $display("Error %0t: count %0d, expected %0d", $time, got, want);
    end
  endtask
  // Drive at a falling edge, judge one registered cycle later
  task automatic step(input logic [4:0] f, input logic [4:0] c, input tsm_sources_t s);
    fs = f;
    cs = c;
    src = s;
    @(negedge i_clk);
    cmp(o_f, pin_exp(1'b1, f, s));
    cmp(o_c, pin_exp(1'b0, c, s));
  endtask
  // Walking one and walking zero under every code; the other pin gets the same code for odd bits, the neighbour code for even bits.
  // Reserved codes are never programmed, as software must keep away from them.
  task automatic sweep_codes();
    tsm_sources_t s;
    logic [4:0] c;
    for (int k = 0; k < 32; k++) begin
      if (k < 18 || k > 22) begin
        for (int b = 0; b < $bits(tsm_sources_t); b++) begin
          c = b[0] ? 5'(k) : 5'(k ^ 1);
          if (c >= 5'h12 && c <= 5'h17) begin
            c = 5'h18;
          end
          s = '0;
          s[b] = 1'b1;
          step(5'(k), c, s);
          step(5'(k), c, ~s);
        end
      end
    end
  endtask
  task automatic pulse_check();
    tsm_sources_t s;
    logic [7:0] f0;
    logic [7:0] c0;
    step(5'h02, 5'h02, '0);
    f0 = f_hi;
    c0 = c_hi;
    s = '0;
    s.late_resync_pulse = 1'b1;
    s.early_resync_pulse = 1'b1;
    step(5'h02, 5'h02, s);
    step(5'h02, 5'h02, '0);
    s = '0;
    s.gain_update_pulse = 1'b1;
    step(5'h0c, 5'h0c, s);
    step(5'h0c, 5'h0c, '0);
    cmp_n(f_hi, f0 + 8'h02);
    cmp_n(c_hi, c0 + 8'h01);
  endtask
  task automatic reset_check();
    fs = 5'h1f;
    cs = 5'h1f;
    i_reset = 1'b1;
    @(negedge i_clk);
    cmp(o_f, 1'b0);
    cmp(o_c, 1'b0);
    i_reset = 1'b0;
    step(5'h1f, 5'h1f, '0);
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (4) @(negedge i_clk);
    i_reset = 1'b0;
    sweep_codes();
    pulse_check();
    reset_check();
    end_of_test();
  end
endmodule
